//--- tripan_consts.vh
`ifndef TRIPAN_CONSTS_VH
`define TRIPAN_CONSTS_VH
// Function
// R1 - flash phase pickup lamp above pickup; time trip if it persists past curve time
// R2 - flash ground pickup lamp above pickup; time trip if it persists past curve time
// R3 - cause lamps latch after a trip until a clear press with power applied
// R4 - trip contact closes until all currents zero, then seals 100 ms more
// R5 - trip lamp stays steady after contact opens until clear; clear kills all trip lamps
// R6 - at trip set cause lamp of every element above pickup or instantaneous level
// R7 - a new trip first erases uncleared older causes
// R8 - clear held 2 s shows last five trip causes, newest first
// R9 - instantaneous trip with no deliberate delay, within 35 ms, independent of pickup
// R10 - phase instantaneous trip sets that phase's instantaneous cause lamp
// R11 - phase time trip sets that phase's time-overcurrent cause lamp
// R12 - ground time trip sets the ground time-overcurrent cause lamp
// R13 - neutral above ground instantaneous level trips and sets its cause lamp
// R14 - self checks at power-up gate health lamp and protection; checks continue
// R15 - internal failure drops health lamp, lights fault lamp, drops service output
// R16 - health lamp flashes in simulation mode
// R17 - service coil energized in normal operation, failsafe on withdrawal
// R18 - bargraph shows largest rms phase current in percent of ct rating
// R19 - bargraph all off below 10%, all on above 100%, filled in between
// R20 - pickup selector off disables that element's time pickup and trip
// R21 - time multiplier 1 to 10, trip time proportional to it
// R22 - ground instantaneous threshold 0.1 to 16 times ground ct rating
// R23 - clear hold timed by a counter; early release is an ordinary clear

// time base
`define TA_CLK_NS 40
`define TA_MS_NS 1000000
`define TA_SEAL_MS 12'h064
`define TA_HOLD_MS 12'h7d0
`define TA_BLINK_MS 12'h0fa
`define TA_SHOW_MS 12'h3e8

// settings limits
`define TA_MULT_MIN 4'h1
`define TA_MULT_MAX 4'ha
`define TA_GI_MIN 8'h01
`define TA_GI_MAX 8'ha0
`define TA_BAR_STEP 8'h0a
`define TA_BAR_SEGS 10

// trip history
`define TA_HIST_DEPTH 3'h5
`define TA_HIST_LAST 3'h4

// cause word layout
`define TA_C_PTOC 2:0
`define TA_C_PINST 5:3
`define TA_C_GTOC 6
`define TA_C_GINST 7
`endif

//--- tripan_hist_mem.v
`include "tripan_consts.vh"

module tripan_hist_mem (
   input wire clk_i,
   input wire we_i,
   input wire [2:0] waddr_i,
   input wire [7:0] wdata_i,
   input wire [2:0] raddr_i,
   output reg [7:0] rdata_o
);

   reg [7:0] mem_q [0:4];

   always @(posedge clk_i) begin
      if (we_i && waddr_i <= `TA_HIST_LAST) begin
         mem_q[waddr_i] <= wdata_i;
      end
      // registered read; addresses past the last slot read zero, but slots never written are not cleared
      if (raddr_i <= `TA_HIST_LAST) begin
         rdata_o <= mem_q[raddr_i];
      end else begin
         rdata_o <= 8'h00;
      end
   end

endmodule

//--- tripan_top.v
`include "tripan_consts.vh"

module tripan_top #(
   parameter MS_CYCLES = `TA_MS_NS / `TA_CLK_NS
) (
   input wire clk_i,
   input wire reset_i,
   input wire [2:0] phase_above_pu_i,
   input wire ground_above_pu_i,
   input wire [2:0] phase_above_inst_i,
   input wire [11:0] ground_x10_i,
   input wire [7:0] ground_inst_set_i,
   input wire phase_pu_off_i,
   input wire ground_pu_off_i,
   input wire [15:0] phase_curve_ms_i,
   input wire [15:0] ground_curve_ms_i,
   input wire [3:0] phase_mult_i,
   input wire [3:0] ground_mult_i,
   input wire currents_zero_i,
   input wire [7:0] phase_pct_i,
   input wire clear_key_i,
   input wire check_done_i,
   input wire check_pass_i,
   input wire internal_fault_i,
   input wire sim_mode_i,
   output reg phase_pu_lamp_o,
   output reg ground_pu_lamp_o,
   output reg [2:0] phase_toc_lamp_o,
   output reg [2:0] phase_inst_lamp_o,
   output reg ground_toc_lamp_o,
   output reg ground_inst_lamp_o,
   output reg trip_lamp_o,
   output reg trip_contact_o,
   output reg service_coil_o,
   output reg health_lamp_o,
   output reg fault_lamp_o,
   output reg protect_en_o,
   output reg [9:0] bargraph_o
);

   ////////////////////////////////////////////////////////////////////////////
   // helpers

   function [3:0] clamp_mult;
      input [3:0] m;
      begin
         if (m < `TA_MULT_MIN) begin
            clamp_mult = `TA_MULT_MIN;
         end else if (m > `TA_MULT_MAX) begin
            clamp_mult = `TA_MULT_MAX;
         end else begin
            clamp_mult = m;
         end
      end
   endfunction

   function [2:0] hist_prev;
      input [2:0] p;
      begin
         if (p == 3'h0) begin
            hist_prev = `TA_HIST_LAST;
         end else begin
            hist_prev = p - 3'h1;
         end
      end
   endfunction

   function [2:0] hist_next;
      input [2:0] p;
      begin
         if (p >= `TA_HIST_LAST) begin
            hist_next = 3'h0;
         end else begin
            hist_next = p + 3'h1;
         end
      end
   endfunction

   localparam [14:0] MS_LAST = MS_CYCLES[14:0] - 15'h0001;

   localparam [2:0] ST_CHECK = 3'h1;
   localparam [2:0] ST_RUN = 3'h2;
   localparam [2:0] ST_FAIL = 3'h4;

   ////////////////////////////////////////////////////////////////////////////
   // millisecond tick and lamp blink

   reg [14:0] div_q;
   reg ms_tick_q;
   reg [11:0] blink_cnt_q;
   reg blink_q;

   always @(posedge clk_i) begin
      if (reset_i) begin
         div_q <= 15'h0000;
         ms_tick_q <= 1'b0;
         blink_cnt_q <= 12'h000;
         blink_q <= 1'b0;
      end else begin
         ms_tick_q <= (div_q == MS_LAST);
         if (div_q == MS_LAST) begin
            div_q <= 15'h0000;
         end else begin
            div_q <= div_q + 15'h0001;
         end
         if (ms_tick_q) begin
            if (blink_cnt_q == `TA_BLINK_MS - 12'h001) begin
               blink_cnt_q <= 12'h000;
               blink_q <= ~blink_q;
            end else begin
               blink_cnt_q <= blink_cnt_q + 12'h001;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // health supervision

   reg [2:0] state_q;
   reg [2:0] state_d;

   always @* begin
      state_d = state_q;
      case (state_q)
         ST_CHECK: begin
            if (check_done_i) begin
               state_d = check_pass_i ? ST_RUN : ST_FAIL; // [R14]
            end
         end
         ST_RUN: begin
            // checks keep running; a failure is final until power cycles
            if (internal_fault_i) begin
               state_d = ST_FAIL; // [R14] [R15]
            end
         end
         ST_FAIL: begin
            state_d = ST_FAIL;
         end
         default: begin
            state_d = ST_CHECK;
         end
      endcase
   end

   wire run = (state_q == ST_RUN);

   ////////////////////////////////////////////////////////////////////////////
   // element detection

   wire [2:0] ppu = phase_pu_off_i ? 3'h0 : phase_above_pu_i; // [R20]
   wire gpu = ground_pu_off_i ? 1'b0 : ground_above_pu_i; // [R20]
   wire [7:0] gi_set = (ground_inst_set_i < `TA_GI_MIN) ? `TA_GI_MIN :
                       (ground_inst_set_i > `TA_GI_MAX) ? `TA_GI_MAX :
                       ground_inst_set_i; // [R22]
   wire ginst = (ground_x10_i >= {4'h0, gi_set}); // [R13] [R22]
   wire [19:0] plim = phase_curve_ms_i * clamp_mult(phase_mult_i); // [R21]
   wire [19:0] glim = ground_curve_ms_i * clamp_mult(ground_mult_i); // [R21]

   reg [19:0] ptoc_cnt_q;
   reg [19:0] gtoc_cnt_q;

   wire ptoc_hit = (|ppu) && (ptoc_cnt_q >= plim); // [R1] [R11]
   wire gtoc_hit = gpu && (gtoc_cnt_q >= glim); // [R2] [R12]
   // instantaneous needs no timer, so the trip lands a cycle after the level
   wire inst_hit = (|phase_above_inst_i) || ginst; // [R9]

   reg trip_contact_q;
   wire trip_go = run && !trip_contact_q && (ptoc_hit || gtoc_hit || inst_hit);

   reg [7:0] causes_now;

   always @* begin
      causes_now = 8'h00;
      causes_now[`TA_C_PTOC] = ppu; // [R6] [R11]
      causes_now[`TA_C_PINST] = phase_above_inst_i; // [R6] [R10]
      causes_now[`TA_C_GTOC] = gpu; // [R6] [R12]
      causes_now[`TA_C_GINST] = ginst; // [R6] [R13]
   end

   always @(posedge clk_i) begin
      if (reset_i) begin
         ptoc_cnt_q <= 20'h00000;
         gtoc_cnt_q <= 20'h00000;
      end else begin
         // the curve timer restarts whenever the element drops out
         if (!(|ppu) || trip_go) begin
            ptoc_cnt_q <= 20'h00000;
         end else if (ms_tick_q && ptoc_cnt_q != 20'hfffff) begin
            ptoc_cnt_q <= ptoc_cnt_q + 20'h00001; // [R1]
         end
         if (!gpu || trip_go) begin
            gtoc_cnt_q <= 20'h00000;
         end else if (ms_tick_q && gtoc_cnt_q != 20'hfffff) begin
            gtoc_cnt_q <= gtoc_cnt_q + 20'h00001; // [R2]
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // clear key: short press clears, long hold replays history

   reg key_q;
   reg [11:0] hold_cnt_q;
   reg hold_done_q;
   reg hist_on_q;
   reg [2:0] show_idx_q;
   reg [2:0] shown_q;
   reg [11:0] show_cnt_q;
   reg [2:0] wr_ptr_q;

   wire key_up = key_q && !clear_key_i;
   wire clear_evt = key_up && !hold_done_q; // [R23]
   wire hold_hit = clear_key_i && !hold_done_q && ms_tick_q &&
                   (hold_cnt_q == `TA_HOLD_MS - 12'h001); // [R8] [R23]

   always @(posedge clk_i) begin
      if (reset_i) begin
         key_q <= 1'b0;
         hold_cnt_q <= 12'h000;
         hold_done_q <= 1'b0;
         hist_on_q <= 1'b0;
         show_idx_q <= 3'h0;
         shown_q <= 3'h0;
         show_cnt_q <= 12'h000;
      end else begin
         key_q <= clear_key_i;
         if (!clear_key_i) begin
            hold_cnt_q <= 12'h000;
            hold_done_q <= 1'b0;
         end else if (hold_hit) begin
            hold_done_q <= 1'b1;
         end else if (ms_tick_q && !hold_done_q) begin
            hold_cnt_q <= hold_cnt_q + 12'h001; // [R23]
         end
         if (hold_hit) begin
            // start at the newest record
            hist_on_q <= 1'b1;
            show_idx_q <= hist_prev(wr_ptr_q); // [R8]
            shown_q <= 3'h0;
            show_cnt_q <= 12'h000;
         end else if (hist_on_q && ms_tick_q) begin
            if (show_cnt_q == `TA_SHOW_MS - 12'h001) begin
               show_cnt_q <= 12'h000;
               show_idx_q <= hist_prev(show_idx_q); // [R8]
               if (shown_q == `TA_HIST_LAST) begin
                  hist_on_q <= 1'b0;
               end else begin
                  shown_q <= shown_q + 3'h1;
               end
            end else begin
               show_cnt_q <= show_cnt_q + 12'h001;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // trip contact, cause latch and history

   reg [7:0] cause_q;
   reg trip_lamp_q;
   reg [11:0] seal_cnt_q;
   wire [7:0] hist_rdata;

   always @(posedge clk_i) begin
      if (reset_i) begin
         trip_contact_q <= 1'b0;
         seal_cnt_q <= 12'h000;
         cause_q <= 8'h00;
         trip_lamp_q <= 1'b0;
         wr_ptr_q <= 3'h0;
      end else begin
         if (trip_go) begin
            // new causes replace old ones; a trip wins over a same-cycle clear
            cause_q <= causes_now; // [R3] [R6] [R7]
            trip_lamp_q <= 1'b1; // [R5]
            trip_contact_q <= 1'b1; // [R4]
            seal_cnt_q <= 12'h000;
            wr_ptr_q <= hist_next(wr_ptr_q); // [R8]
         end else begin
            if (trip_contact_q) begin
               if (!currents_zero_i) begin
                  seal_cnt_q <= 12'h000; // [R4]
               end else if (ms_tick_q) begin
                  if (seal_cnt_q == `TA_SEAL_MS - 12'h001) begin
                     trip_contact_q <= 1'b0; // [R4]
                  end else begin
                     seal_cnt_q <= seal_cnt_q + 12'h001;
                  end
               end
            end
            // a clear is ignored while the contact is closed so a live trip stays shown
            if (clear_evt && !trip_contact_q) begin
               cause_q <= 8'h00; // [R3] [R5]
               trip_lamp_q <= 1'b0; // [R5]
            end
         end
      end
   end

   tripan_hist_mem u_hist (
      .clk_i(clk_i),
      .we_i(trip_go),
      .waddr_i(wr_ptr_q),
      .wdata_i(causes_now),
      .raddr_i(show_idx_q),
      .rdata_o(hist_rdata)
   );

   ////////////////////////////////////////////////////////////////////////////
   // bargraph

   reg [9:0] bar_d;
   reg [7:0] bar_th;
   integer k;

   always @* begin
      bar_d = 10'h000;
      bar_th = 8'h00;
      for (k = 0; k < `TA_BAR_SEGS; k = k + 1) begin
         bar_th = bar_th + `TA_BAR_STEP;
         bar_d[k] = (phase_pct_i >= bar_th); // [R18] [R19]
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // output registers

   wire [7:0] lamp_word = hist_on_q ? hist_rdata : cause_q; // [R8]

   always @(posedge clk_i) begin
      if (reset_i) begin
         state_q <= ST_CHECK;
         phase_pu_lamp_o <= 1'b0;
         ground_pu_lamp_o <= 1'b0;
         phase_toc_lamp_o <= 3'h0;
         phase_inst_lamp_o <= 3'h0;
         ground_toc_lamp_o <= 1'b0;
         ground_inst_lamp_o <= 1'b0;
         trip_lamp_o <= 1'b0;
         trip_contact_o <= 1'b0;
         service_coil_o <= 1'b0;
         health_lamp_o <= 1'b0;
         fault_lamp_o <= 1'b0;
         protect_en_o <= 1'b0;
         bargraph_o <= 10'h000;
      end else begin
         state_q <= state_d;
         phase_pu_lamp_o <= (|ppu) && blink_q; // [R1]
         ground_pu_lamp_o <= gpu && blink_q; // [R2]
         phase_toc_lamp_o <= lamp_word[`TA_C_PTOC]; // [R3]
         phase_inst_lamp_o <= lamp_word[`TA_C_PINST]; // [R3]
         ground_toc_lamp_o <= lamp_word[`TA_C_GTOC]; // [R3]
         ground_inst_lamp_o <= lamp_word[`TA_C_GINST]; // [R3]
         trip_lamp_o <= hist_on_q ? (|hist_rdata) : trip_lamp_q; // [R5]
         trip_contact_o <= trip_contact_q; // [R4]
         // coil held only while healthy: power loss or failure both drop it
         service_coil_o <= run; // [R15] [R17]
         health_lamp_o <= run && (!sim_mode_i || blink_q); // [R14] [R16]
         fault_lamp_o <= (state_q == ST_FAIL); // [R15]
         protect_en_o <= run; // [R14]
         bargraph_o <= bar_d; // [R19]
      end
   end

endmodule

//--- tripan_breaker.sv
// breaker trip circuit: opens a set time after the trip contact closes,
// then stays open until the bench recloses it, as a tripped breaker would
module tripan_breaker (
   input logic clk_i,
   input logic reset_i,
   input logic trip_i,
   input logic close_i,
   input logic [7:0] dly_i,
   output logic open_o
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [7:0] cnt_q;
   always @(posedge clk_i) begin
      if (reset_i || close_i) begin
         cnt_q <= 8'h00;
         open_o <= 1'b0;
      end else if (trip_i && !open_o) begin
         cnt_q <= cnt_q + 8'h01;
         if (cnt_q >= dly_i) open_o <= 1'b1;
      end
   end
endmodule

//--- tripan_top_assertions.sv
module tripan_top_chk #(
   parameter MS_CYCLES = 4
) (
   input logic clk_i,
   input logic reset_i,
   input logic [2:0] phase_above_pu_i,
   input logic [2:0] phase_above_inst_i,
   input logic [11:0] ground_x10_i,
   input logic [7:0] ground_inst_set_i,
   input logic phase_pu_off_i,
   input logic currents_zero_i,
   input logic [7:0] phase_pct_i,
   input logic check_done_i,
   input logic check_pass_i,
   input logic internal_fault_i,
   input logic phase_pu_lamp_o,
   input logic trip_lamp_o,
   input logic trip_contact_o,
   input logic service_coil_o,
   input logic health_lamp_o,
   input logic fault_lamp_o,
   input logic protect_en_o,
   input logic [9:0] bargraph_o
);
   timeunit 1ns;
   timeprecision 100ps;
   // tick phase is unknown to the checker, so the seal window allows one ms under and two ms over
   localparam int SEAL_LO = 99 * MS_CYCLES;
   localparam int SEAL_HI = 102 * MS_CYCLES;
   int zero_cnt;
   default clocking @(posedge clk_i); endclocking
   default disable iff (reset_i);
   function automatic logic [9:0] seg_f(input logic [7:0] p);
      for (int k = 0; k < 10; k++) seg_f[k] = p >= 10 * (k + 1);
   endfunction
   always @(posedge clk_i) begin
      if (reset_i) zero_cnt <= 0;
      else zero_cnt <= currents_zero_i ? zero_cnt + 1 : 0;
   end
   ////////////////////////////////////////////////////////////////////////////////
   sequence s_inst;
      protect_en_o && !trip_contact_o && |phase_above_inst_i;
   endsequence
   sequence s_gnd;
      protect_en_o && !trip_contact_o && ground_inst_set_i inside {[1:160]} &&
         ground_x10_i >= {4'h0, ground_inst_set_i};
   endsequence
   sequence s_ok;
      check_done_i && check_pass_i && !internal_fault_i && !protect_en_o && !fault_lamp_o;
   endsequence
   a_inst_trip_fast: assert property (s_inst |-> ##2 trip_contact_o && trip_lamp_o)
      else $error("phase instantaneous trip late");
   a_gnd_inst_trip: assert property (s_gnd |-> ##2 trip_contact_o)
      else $error("ground instantaneous trip late");
   // a seal that ends just as current returns is legal, so the step before must be live too
   sequence s_live;
      trip_contact_o && !currents_zero_i && !$past(currents_zero_i);
   endsequence
   sequence s_no_pu;
      !(|phase_above_pu_i) || phase_pu_off_i;
   endsequence
   sequence s_down;
      fault_lamp_o && !health_lamp_o && !service_coil_o;
   endsequence
   sequence s_lamp2;
      trip_lamp_o ##1 trip_lamp_o;
   endsequence
   logic seal_ok;
   assign seal_ok = zero_cnt >= SEAL_LO && zero_cnt <= SEAL_HI;
   a_contact_holds: assert property (s_live |=> trip_contact_o)
      else $error("trip contact opened with current flowing");
   a_seal_time: assert property ($fell(trip_contact_o) |-> seal_ok)
      else $error("trip contact seal time wrong");
   a_pu_lamp_off: assert property (s_no_pu [*2] |-> !phase_pu_lamp_o)
      else $error("phase pickup lamp lit without pickup");
   a_fault_resp: assert property (internal_fault_i |-> ##2 s_down)
      else $error("internal fault not annunciated");
   a_run_start: assert property (s_ok |-> ##2 protect_en_o && service_coil_o)
      else $error("protection not enabled after passing checks");
   a_bar_map: assert property (1 |=> bargraph_o == seg_f($past(phase_pct_i)))
      else $error("bargraph segments wrong");
   a_lamp_after_open: assert property ($fell(trip_contact_o) |-> s_lamp2)
      else $error("trip lamp dropped when contact opened");
endmodule

bind tripan_top tripan_top_chk #(.MS_CYCLES(MS_CYCLES)) u_chk (.*);

//--- tripan_top_tb.sv
module tripan_top_tb;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int MS = 4;
   logic clk_i = 0, reset_i = 1, gpu_r = 0, close_r = 0, brk_open, lp, hl, gl;
   logic [2:0] pu_r = 0, inst_r = 0, phase_above_pu_i, phase_above_inst_i;
   logic [11:0] gx_r = 0, ground_x10_i;
   logic [7:0] dly_r = 0, ground_inst_set_i = 8'h0a, phase_pct_i = 8'h00;
   logic ground_above_pu_i, currents_zero_i, phase_pu_off_i = 0, ground_pu_off_i = 0;
   logic clear_key_i = 0, check_done_i = 0, check_pass_i = 0, internal_fault_i = 0;
   logic sim_mode_i = 0;
   logic [15:0] phase_curve_ms_i = 16'hffff, ground_curve_ms_i = 16'hffff;
   logic [3:0] phase_mult_i = 4'h1, ground_mult_i = 4'h1;
   logic phase_pu_lamp_o, ground_pu_lamp_o, ground_toc_lamp_o, ground_inst_lamp_o;
   logic trip_lamp_o, trip_contact_o, service_coil_o, health_lamp_o, fault_lamp_o;
   logic protect_en_o;
   logic [2:0] phase_toc_lamp_o, phase_inst_lamp_o;
   logic [9:0] bargraph_o;
   logic [7:0] bnd[6] = '{8'h09, 8'h0a, 8'h63, 8'h64, 8'h65, 8'hff};
   logic [7:0] hist[$];
   int errors = 0, comparisons = 0, nb, nh, ng;
   wire [7:0] lamps = {ground_inst_lamp_o, ground_toc_lamp_o,
                       phase_inst_lamp_o, phase_toc_lamp_o};
   // fault currents vanish once the breaker has opened
   assign phase_above_pu_i = pu_r & {3{~brk_open}};
   assign phase_above_inst_i = inst_r & {3{~brk_open}};
   assign ground_above_pu_i = gpu_r & ~brk_open;
   assign ground_x10_i = brk_open ? 12'h000 : gx_r;
   assign currents_zero_i = brk_open;
   always #20 clk_i = ~clk_i;
   tripan_top #(.MS_CYCLES(MS)) dut (.*);
   tripan_breaker brk (.clk_i(clk_i), .reset_i(reset_i), .trip_i(trip_contact_o),
      .close_i(close_r), .dly_i(dly_r), .open_o(brk_open));
   ////////////////////////////////////////////////////////////////////////////////
   task step(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   task chk(input string nm, input logic [9:0] e, input logic [9:0] g);
      comparisons++;
      if (g !== e) begin
         errors++;
         $display("CHECK FAILED %s exp %h got %h", nm, e, g);
      end
   endtask
   function automatic logic [9:0] bar(input int p);
      for (int k = 0; k < 10; k++) bar[k] = p >= 10 * (k + 1);
   endfunction
   task automatic trip(input int lim, input logic [7:0] c);
      int n;
      n = 0;
      dly_r = 8'($urandom_range(0, 40));
      while (trip_contact_o !== 1'b1 && n < lim) begin
         step(1);
         n++;
      end
      chk("contact", 1, trip_contact_o);
      chk("cause", c, lamps);
      hist.push_front(c);
      n = 0;
      while (brk_open !== 1'b1 && n < 60) begin
         step(1);
         n++;
      end
      n = 0;
      while (trip_contact_o === 1'b1 && n < 200 * MS) begin
         step(1);
         n++;
      end
      chk("seal", 1, n >= 98 * MS && n <= 102 * MS);
      chk("trip lamp", 1, trip_lamp_o);
      chk("held cause", c, lamps);
      pu_r = 0;
      inst_r = 0;
      gpu_r = 0;
      gx_r = 0;
      close_r = 1;
      step(1);
      close_r = 0;
      step(2);
   endtask
   task clr;
      clear_key_i = 1;
      step(5);
      clear_key_i = 0;
      step(3);
      chk("cleared", 0, {lamps, trip_lamp_o});
   endtask
   task conclude;
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(33887));
      step(10);
      reset_i = 0;
      step(3);
      chk("pre check", 0, {health_lamp_o, service_coil_o, protect_en_o});
      check_done_i = 1;
      check_pass_i = 1;
      step(3);
      chk("in service", 3'b111, {health_lamp_o, service_coil_o, protect_en_o});
      for (int i = 0; i < 12; i++) begin
         phase_pct_i = i < 6 ? bnd[i] : 8'($urandom);
         step(2);
         chk("bargraph", bar(phase_pct_i), bargraph_o);
      end
      inst_r = 3'b101;
      gpu_r = 1;
      trip(35 * MS, 8'h68);
      gx_r = 12'h009;
      step(10);
      chk("below ground inst", 0, trip_contact_o);
      gx_r = 12'h00a;
      trip(35 * MS, 8'h80);
      clr;
      phase_curve_ms_i = 16'h0003;
      phase_mult_i = 4'h2;
      pu_r = 3'b010;
      step(5 * MS);
      chk("early time trip", 0, trip_contact_o);
      trip(4 * MS, 8'h02);
      ground_pu_off_i = 1;
      ground_curve_ms_i = 16'h0002;
      ground_mult_i = 4'h0;
      gpu_r = 1;
      step(10 * MS);
      chk("ground pickup off", 0, {trip_contact_o, ground_pu_lamp_o});
      ground_pu_off_i = 0;
      trip(6 * MS, 8'h40);
      pu_r = 3'b001;
      gpu_r = 1;
      sim_mode_i = 1;
      phase_curve_ms_i = 16'hffff;
      ground_curve_ms_i = 16'hffff;
      nb = 0;
      nh = 0;
      ng = 0;
      for (int i = 0; i < 600 * MS; i++) begin
         lp = phase_pu_lamp_o;
         hl = health_lamp_o;
         gl = ground_pu_lamp_o;
         step(1);
         nb += int'(lp !== phase_pu_lamp_o);
         nh += int'(hl !== health_lamp_o);
         ng += int'(gl !== ground_pu_lamp_o);
      end
      chk("pickup flash", 1, nb >= 2 && nb <= 4);
      chk("ground flash", 1, ng >= 2 && ng <= 4);
      chk("sim flash", 1, nh >= 2 && nh <= 4);
      pu_r = 0;
      gpu_r = 0;
      sim_mode_i = 0;
      inst_r = 3'b010;
      trip(35 * MS, 8'h10);
      // sample each replayed record mid-slot so tick phase cannot matter
      clear_key_i = 1;
      step(2500 * MS);
      for (int i = 0; i < 5; i++) begin
         chk("record", {hist[i], 1'b1}, {lamps, trip_lamp_o});
         step(1000 * MS);
      end
      clear_key_i = 0;
      step(10);
      internal_fault_i = 1;
      step(3);
      chk("fault", 3'b100, {fault_lamp_o, health_lamp_o, service_coil_o});
      conclude;
   end
   initial begin
      repeat (60000) @(posedge clk_i);
      errors++;
      conclude;
   end
endmodule
